// *** lmf_ctrl_model.sv ***
// Behavioural chain controller: free serial clock, frame sender, forwarded-frame catcher
`timescale 1ns/1ps
module lmf_ctrl_model (
  output logic serial_clk_o,
  output logic serial_in_o,
  input wire logic serial_out_i,
  output logic [lmf_pkg::FRAME_W-1:0] rx_frame_o,
  output logic [15:0] rx_count_o
);
  logic [6:0] bit_cnt;
  logic [63:0] shift;

  initial begin
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
    rx_count_o = 16'h0000;
    rx_frame_o = 64'h0;
    bit_cnt = 7'h00;
    shift = 64'h0;
    // Runs even between frames since the forwarded frame is shifted out on its falls
    forever #32 serial_clk_o = ~serial_clk_o;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Start bit, then command, address, payload msb first, changed on the fall
  task automatic send(input logic [7:0] cmd, input logic [7:0] addr, input logic [47:0] pay);
    logic [64:0] f;
    f = {1'b1, cmd, addr, pay};
    for (int i = 64; i >= 0; i--) begin
      @(negedge serial_clk_o);
      serial_in_o <= f[i];
    end
    @(negedge serial_clk_o);
    serial_in_o <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Catches the forwarded frame on the serial output at the rising edge
  always @(posedge serial_clk_o) begin
    if (bit_cnt == 7'h00) begin
      if (serial_out_i === 1'b1) begin
        bit_cnt <= 7'h01;
      end
    end else begin
      shift <= {shift[62:0], serial_out_i};
      if (bit_cnt == 7'h40) begin
        bit_cnt <= 7'h00;
        rx_frame_o <= {shift[62:0], serial_out_i};
        rx_count_o <= rx_count_o + 16'h0001;
      end else begin
        bit_cnt <= bit_cnt + 7'h01;
      end
    end
  end
endmodule

// *** lmf_frame_cmd.sv ***
// Serial command interpreter and frame update flow of one chained matrix driver
//
// Overview of operation
// RULE1: Blank extension field held at bits 46..41.
// RULE2: Controller indexes chain before writing configuration.
// RULE3: Controller sends sync, then frame data.
// RULE4: Sync flips banks: show old, fill new.
// RULE5: Reads answered any time within a frame.
// RULE6: Each device keeps its own distinct address.
// RULE7: Configuration written by broadcast data write.
// RULE8: Words 0,1 wait for sync; others immediate.
// RULE9: Grayscale written by addressed data write.
// RULE10: Fault read commands return open/short flags.
// RULE11: Controller orders channel data by wiring.
// RULE12: Brightness code and colour gains scale current.
// RULE13: Controller keeps serial clock running always.
// RULE14: All traffic in on serial_in, out serial_out.
// RULE15: Shadow words copied in the sync cycle.
`timescale 1ns/1ps
module lmf_frame_cmd (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic [lmf_pkg::FAULT_W-1:0] led_open_detect_i,
  input wire logic [lmf_pkg::FAULT_W-1:0] led_short_detect_i,
  input wire logic [lmf_pkg::ROW_AW-1:0] display_addr_i,
  output logic serial_out_o,
  output logic [lmf_pkg::CFG_W-1:0] display_data_o,
  output logic display_bank_o,
  output logic vsync_pulse_o,
  output logic [lmf_pkg::ADDR_W-1:0] chip_address_o,
  output logic chip_indexed_o,
  output logic [lmf_pkg::BLK_EXT_W-1:0] subperiod_blank_extension_o,
  output logic [lmf_pkg::BC_W-1:0] global_brightness_code_o,
  output logic [lmf_pkg::SCALE_W-1:0] red_current_scale_o,
  output logic [lmf_pkg::SCALE_W-1:0] green_current_scale_o,
  output logic [lmf_pkg::SCALE_W-1:0] blue_current_scale_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Take the third stage where stages two and three agree, else hold
  function automatic logic [lmf_pkg::FAULT_W-1:0] settle(
    input logic [lmf_pkg::FAULT_W-1:0] s2,
    input logic [lmf_pkg::FAULT_W-1:0] s3,
    input logic [lmf_pkg::FAULT_W-1:0] hold
  );
    settle = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & hold);
  endfunction

  // Current scale: (global code + 1) times colour gain
  function automatic logic [lmf_pkg::SCALE_W-1:0] current_scale(
    input logic [lmf_pkg::BC_W-1:0] bc,
    input logic [lmf_pkg::CC_W-1:0] cc
  );
    logic [lmf_pkg::BC_W:0] step;
    step = {1'b0, bc} + 4'h1;
    current_scale = step * cc;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0] sclk_sync_ff;
  logic [2:0] sin_sync_ff;
  logic sclk_lvl_ff;
  logic sin_lvl_ff;
  logic sclk_agree;
  logic sclk_rise;
  logic sclk_fall;
  logic sin_now;
  logic [lmf_pkg::FAULT_W-1:0] open_s1_ff, open_s2_ff, open_s3_ff, open_ff;
  logic [lmf_pkg::FAULT_W-1:0] short_s1_ff, short_s2_ff, short_s3_ff, short_ff;
  lmf_pkg::lmf_rx_state_t rx_state_ff;
  logic [lmf_pkg::CNT_W-1:0] rx_cnt_ff;
  logic [lmf_pkg::FRAME_W-1:0] rx_sreg_ff;
  logic rx_done;
  logic [lmf_pkg::FRAME_W-1:0] rx_word;
  logic [lmf_pkg::CMD_W-1:0] cmd;
  logic [lmf_pkg::OP_W-1:0] op;
  logic [lmf_pkg::SUB_W-1:0] sub;
  logic [lmf_pkg::ADDR_W-1:0] addr;
  logic [lmf_pkg::CFG_W-1:0] payload;
  logic is_mine;
  logic is_bcast;
  logic do_index, do_cfg_wr, do_gray_wr, do_vsync, do_cfg_rd, do_flt_rd;
  logic [lmf_pkg::FRAME_W-1:0] nxt_fwd;
  logic [lmf_pkg::ADDR_W-1:0] chip_addr_ff;
  logic chip_indexed_ff;
  logic [lmf_pkg::CFG_W-1:0] cfg0_shadow_ff, cfg1_shadow_ff;
  logic [lmf_pkg::CFG_W-1:0] cfg0_act_ff, cfg1_act_ff, cfg2_act_ff, cfg3_act_ff;
  logic bank_ff;
  logic [lmf_pkg::ROW_AW-1:0] wr_ptr_ff;
  logic vsync_ff;
  logic [lmf_pkg::FRAME_W:0] tx_sreg_ff;
  logic [lmf_pkg::CNT_W-1:0] tx_cnt_ff;
  logic serial_out_ff;
  logic [lmf_pkg::SCALE_W-1:0] red_scale_ff, green_scale_ff, blue_scale_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: serial clock is sampled, never used as a clock
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_sync_ff <= 3'h0;
      sin_sync_ff <= 3'h0;
      sclk_lvl_ff <= 1'b0;
      sin_lvl_ff <= 1'b0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk_i};
      sin_sync_ff <= {sin_sync_ff[1:0], serial_in_i};
      sclk_lvl_ff <= sclk_agree ? sclk_sync_ff[2] : sclk_lvl_ff;
      sin_lvl_ff <= sin_now;
    end
  end

  assign sclk_agree = (sclk_sync_ff[1] == sclk_sync_ff[2]);
  assign sclk_rise = sclk_agree & sclk_sync_ff[2] & ~sclk_lvl_ff;
  assign sclk_fall = sclk_agree & ~sclk_sync_ff[2] & sclk_lvl_ff;
  assign sin_now = (sin_sync_ff[1] == sin_sync_ff[2]) ? sin_sync_ff[2] : sin_lvl_ff;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      open_s1_ff <= '0;
      open_s2_ff <= '0;
      open_s3_ff <= '0;
      open_ff <= '0;
      short_s1_ff <= '0;
      short_s2_ff <= '0;
      short_s3_ff <= '0;
      short_ff <= '0;
    end else begin
      open_s1_ff <= led_open_detect_i;
      open_s2_ff <= open_s1_ff;
      open_s3_ff <= open_s2_ff;
      open_ff <= settle(open_s2_ff, open_s3_ff, open_ff);
      short_s1_ff <= led_short_detect_i;
      short_s2_ff <= short_s1_ff;
      short_s3_ff <= short_s2_ff;
      short_ff <= settle(short_s2_ff, short_s3_ff, short_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver: start bit, then 64 bits msb first on serial clock rises
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_state_ff <= lmf_pkg::LMF_RX_IDLE;
      rx_cnt_ff <= '0;
      rx_sreg_ff <= '0;
    end else if (sclk_rise) begin
      unique case (rx_state_ff)
        lmf_pkg::LMF_RX_IDLE: begin
          rx_cnt_ff <= '0;
          if (sin_now) begin // [RULE14]
            rx_state_ff <= lmf_pkg::LMF_RX_SHIFT;
          end
        end
        lmf_pkg::LMF_RX_SHIFT: begin
          rx_sreg_ff <= rx_word;
          rx_cnt_ff <= rx_cnt_ff + 7'h01;
          if (rx_cnt_ff == lmf_pkg::FRAME_LAST) begin
            rx_state_ff <= lmf_pkg::LMF_RX_IDLE;
          end
        end
      endcase
    end
  end

  assign rx_word = {rx_sreg_ff[lmf_pkg::FRAME_W-2:0], sin_now};
  assign rx_done = sclk_rise && (rx_state_ff == lmf_pkg::LMF_RX_SHIFT)
                   && (rx_cnt_ff == lmf_pkg::FRAME_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode and the word forwarded down the chain
  always_comb begin
    cmd = rx_word[lmf_pkg::CMD_LSB +: lmf_pkg::CMD_W];
    op = cmd[lmf_pkg::OP_LSB +: lmf_pkg::OP_W];
    sub = cmd[lmf_pkg::SUB_W-1:0];
    addr = rx_word[lmf_pkg::ADDR_LSB +: lmf_pkg::ADDR_W];
    payload = rx_word[lmf_pkg::CFG_W-1:0];
    is_bcast = (addr == lmf_pkg::BCAST_ADDR);
    is_mine = (addr == chip_addr_ff) && !is_bcast; // [RULE6]
    do_index = rx_done && (op == lmf_pkg::OP_CHIP_INDEX);
    do_cfg_wr = rx_done && (op == lmf_pkg::OP_DATA_WRITE) && is_bcast
                && (sub < 4'(lmf_pkg::CFG_NUM));
    do_gray_wr = rx_done && (op == lmf_pkg::OP_DATA_WRITE) && is_mine;
    do_vsync = rx_done && (op == lmf_pkg::OP_VSYNC);
    do_cfg_rd = rx_done && (op == lmf_pkg::OP_CFG_READ) && is_mine
                && (sub < 4'(lmf_pkg::CFG_NUM));
    do_flt_rd = rx_done && (op == lmf_pkg::OP_FAULT_READ) && is_mine
                && (sub < lmf_pkg::FAULT_SUB_NUM);
    nxt_fwd = rx_word;
    // Next device takes the following address
    if (op == lmf_pkg::OP_CHIP_INDEX) begin
      nxt_fwd[lmf_pkg::ADDR_LSB +: lmf_pkg::ADDR_W] = addr + 8'h01; // [RULE6]
    end
    if (do_cfg_rd) begin // [RULE5]
      case (sub[1:0])
        2'h0: nxt_fwd[lmf_pkg::CFG_W-1:0] = cfg0_act_ff;
        2'h1: nxt_fwd[lmf_pkg::CFG_W-1:0] = cfg1_act_ff;
        2'h2: nxt_fwd[lmf_pkg::CFG_W-1:0] = cfg2_act_ff;
        default: nxt_fwd[lmf_pkg::CFG_W-1:0] = cfg3_act_ff;
      endcase
    end
    if (do_flt_rd) begin // [RULE10] [RULE5]
      case (sub[2:0])
        3'h0: nxt_fwd[lmf_pkg::CFG_W-1:0] = open_ff[0 +: lmf_pkg::CFG_W];
        3'h1: nxt_fwd[lmf_pkg::CFG_W-1:0] = open_ff[lmf_pkg::CFG_W +: lmf_pkg::CFG_W];
        3'h2: nxt_fwd[lmf_pkg::CFG_W-1:0] = open_ff[2*lmf_pkg::CFG_W +: lmf_pkg::CFG_W];
        3'h3: nxt_fwd[lmf_pkg::CFG_W-1:0] = short_ff[0 +: lmf_pkg::CFG_W];
        3'h4: nxt_fwd[lmf_pkg::CFG_W-1:0] = short_ff[lmf_pkg::CFG_W +: lmf_pkg::CFG_W];
        default: nxt_fwd[lmf_pkg::CFG_W-1:0] = short_ff[2*lmf_pkg::CFG_W +: lmf_pkg::CFG_W];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chain address
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      chip_addr_ff <= lmf_pkg::ADDR_RST;
      chip_indexed_ff <= 1'b0;
    end else if (do_index) begin
      chip_addr_ff <= addr; // [RULE6]
      chip_indexed_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration words: 0 and 1 staged until sync, 2 and 3 at once
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg0_shadow_ff <= lmf_pkg::CFG_RST;
      cfg1_shadow_ff <= lmf_pkg::CFG_RST;
      cfg0_act_ff <= lmf_pkg::CFG_RST;
      cfg1_act_ff <= lmf_pkg::CFG_RST;
      cfg2_act_ff <= lmf_pkg::CFG_RST;
      cfg3_act_ff <= lmf_pkg::CFG_RST;
    end else begin
      if (do_cfg_wr) begin // [RULE7] [RULE8]
        case (sub[1:0])
          2'h0: cfg0_shadow_ff <= payload;
          2'h1: cfg1_shadow_ff <= payload;
          2'h2: cfg2_act_ff <= payload;
          default: cfg3_act_ff <= payload;
        endcase
      end
      if (do_vsync) begin
        cfg0_act_ff <= cfg0_shadow_ff; // [RULE15] [RULE8]
        cfg1_act_ff <= cfg1_shadow_ff; // [RULE15] [RULE1]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale banks: sync shows the filled bank and refills the other
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bank_ff <= 1'b0;
      wr_ptr_ff <= '0;
      vsync_ff <= 1'b0;
    end else begin
      vsync_ff <= do_vsync;
      if (do_vsync) begin
        bank_ff <= ~bank_ff; // [RULE4]
        wr_ptr_ff <= '0;
      end else if (do_gray_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 4'h1; // [RULE9]
      end
    end
  end

  lmf_gray_ram u_gray_ram (
    .core_clk_i(core_clk_i),
    .wr_en_i(do_gray_wr),
    .wr_addr_i({~bank_ff, wr_ptr_ff}),
    .wr_data_i(payload),
    .rd_addr_i({bank_ff, display_addr_i}),
    .rd_data_o(display_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Store-and-forward transmitter, shifts on serial clock falls
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_sreg_ff <= '0;
      tx_cnt_ff <= '0;
      serial_out_ff <= 1'b0;
    end else if (rx_done) begin
      tx_sreg_ff <= {1'b1, nxt_fwd}; // [RULE14]
      tx_cnt_ff <= lmf_pkg::TX_BITS;
    end else if (sclk_fall) begin
      if (tx_cnt_ff != '0) begin
        serial_out_ff <= tx_sreg_ff[lmf_pkg::FRAME_W];
        tx_sreg_ff <= {tx_sreg_ff[lmf_pkg::FRAME_W-1:0], 1'b0};
        tx_cnt_ff <= tx_cnt_ff - 7'h01;
      end else begin
        serial_out_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current scaling from brightness code and colour gains
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      red_scale_ff <= '0;
      green_scale_ff <= '0;
      blue_scale_ff <= '0;
    end else begin
      red_scale_ff <= current_scale(cfg3_act_ff[lmf_pkg::BC_LSB +: lmf_pkg::BC_W],
                                    cfg3_act_ff[lmf_pkg::CC_R_LSB +: lmf_pkg::CC_W]); // [RULE12]
      green_scale_ff <= current_scale(cfg3_act_ff[lmf_pkg::BC_LSB +: lmf_pkg::BC_W],
                                      cfg3_act_ff[lmf_pkg::CC_G_LSB +: lmf_pkg::CC_W]); // [RULE12]
      blue_scale_ff <= current_scale(cfg3_act_ff[lmf_pkg::BC_LSB +: lmf_pkg::BC_W],
                                     cfg3_act_ff[lmf_pkg::CC_B_LSB +: lmf_pkg::CC_W]); // [RULE12]
    end
  end

  assign serial_out_o = serial_out_ff;
  assign display_bank_o = bank_ff;
  assign vsync_pulse_o = vsync_ff;
  assign chip_address_o = chip_addr_ff;
  assign chip_indexed_o = chip_indexed_ff;
  assign subperiod_blank_extension_o =
    cfg1_act_ff[lmf_pkg::BLK_EXT_LSB +: lmf_pkg::BLK_EXT_W]; // [RULE1]
  assign global_brightness_code_o = cfg3_act_ff[lmf_pkg::BC_LSB +: lmf_pkg::BC_W];
  assign red_current_scale_o = red_scale_ff;
  assign green_current_scale_o = green_scale_ff;
  assign blue_current_scale_o = blue_scale_ff;
endmodule

// *** lmf_frame_cmd_assertions.sv ***
// Concurrent checks on the ports of the frame command flow
`timescale 1ns/1ps
module lmf_frame_cmd_assertions (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic serial_clk_i,
  input wire logic serial_out_o,
  input wire logic display_bank_o,
  input wire logic vsync_pulse_o,
  input wire logic [lmf_pkg::ADDR_W-1:0] chip_address_o,
  input wire logic chip_indexed_o,
  input wire logic [lmf_pkg::BLK_EXT_W-1:0] subperiod_blank_extension_o,
  input wire logic [lmf_pkg::BC_W-1:0] global_brightness_code_o,
  input wire logic [lmf_pkg::SCALE_W-1:0] red_current_scale_o,
  input wire logic [lmf_pkg::SCALE_W-1:0] green_current_scale_o,
  input wire logic [lmf_pkg::SCALE_W-1:0] blue_current_scale_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [11:0] bc_inc;
  assign bc_inc = {9'h000, global_brightness_code_o} + 12'h001;

  //////////////////////////////////////////////////////////////////////////////
  pulse_one_cycle_a: assert property (vsync_pulse_o |=> !vsync_pulse_o)
    else $error("sync pulse longer than one cycle");
  pulse_follows_flip_a: assert property (vsync_pulse_o |-> display_bank_o != $past(display_bank_o, 2))
    else $error("sync pulse without bank flip");
  flip_gives_pulse_a: assert property ($changed(display_bank_o) |-> vsync_pulse_o)
    else $error("bank flip without sync pulse");
  blank_at_sync_a: assert property ($changed(subperiod_blank_extension_o) |-> $changed(display_bank_o))
    else $error("staged field changed outside sync");
  scale_product_a: assert property ($stable(global_brightness_code_o) |->
    (red_current_scale_o % bc_inc) == 12'h000 && (green_current_scale_o % bc_inc) == 12'h000 &&
    (blue_current_scale_o % bc_inc) == 12'h000) else $error("scale not a multiple of code");
  index_sticky_a: assert property (chip_indexed_o |=> chip_indexed_o)
    else $error("indexed flag dropped");
  addr_needs_index_a: assert property ($changed(chip_address_o) |-> chip_indexed_o)
    else $error("address changed without index");
  out_after_fall_a: assert property ($changed(serial_out_o) |-> !$past(serial_clk_i, 2))
    else $error("serial output moved outside a fall");

  cover property (vsync_pulse_o);
  cover property ($rose(chip_indexed_o));
  cover property ($changed(global_brightness_code_o));
endmodule

bind lmf_frame_cmd lmf_frame_cmd_assertions lmf_frame_cmd_assertions_i (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .serial_clk_i(serial_clk_i),
  .serial_out_o(serial_out_o), .display_bank_o(display_bank_o), .vsync_pulse_o(vsync_pulse_o),
  .chip_address_o(chip_address_o), .chip_indexed_o(chip_indexed_o),
  .subperiod_blank_extension_o(subperiod_blank_extension_o),
  .global_brightness_code_o(global_brightness_code_o), .red_current_scale_o(red_current_scale_o),
  .green_current_scale_o(green_current_scale_o), .blue_current_scale_o(blue_current_scale_o));

// *** lmf_gray_ram.sv ***
// Two-bank grayscale memory with one write port and a registered read port
`timescale 1ns/1ps
module lmf_gray_ram (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [lmf_pkg::RAM_AW-1:0] wr_addr_i,
  input wire logic [lmf_pkg::CFG_W-1:0] wr_data_i,
  input wire logic [lmf_pkg::RAM_AW-1:0] rd_addr_i,
  output logic [lmf_pkg::CFG_W-1:0] rd_data_o
);
  logic [lmf_pkg::CFG_W-1:0] mem_ff [lmf_pkg::RAM_DEPTH];

  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rd_data_o <= mem_ff[rd_addr_i];
  end
endmodule

// *** lmf_pkg.sv ***
// Shared constants, command codes and field layout of the frame command flow
package lmf_pkg;
  localparam int FRAME_W = 64;
  localparam int CFG_W = 48;
  localparam int CFG_NUM = 4;
  localparam int RAM_AW = 5;
  localparam int RAM_DEPTH = 32;
  localparam int ROW_AW = 4;
  localparam int FAULT_W = 144;
  localparam int CNT_W = 7;

  // Serial frame layout after the start bit: command, address, payload
  localparam int CMD_LSB = 56;
  localparam int ADDR_LSB = 48;
  localparam int CMD_W = 8;
  localparam int ADDR_W = 8;
  localparam int OP_LSB = 4;
  localparam int OP_W = 4;
  localparam int SUB_W = 4;
  localparam logic [CNT_W-1:0] FRAME_LAST = 7'h3F;
  localparam logic [CNT_W-1:0] TX_BITS = 7'h41;

  // Opcodes in the upper nibble of the command byte
  localparam logic [OP_W-1:0] OP_CHIP_INDEX = 4'h1;
  localparam logic [OP_W-1:0] OP_DATA_WRITE = 4'h2;
  localparam logic [OP_W-1:0] OP_VSYNC = 4'h3;
  localparam logic [OP_W-1:0] OP_CFG_READ = 4'h4;
  localparam logic [OP_W-1:0] OP_FAULT_READ = 4'h5;

  // Full fault read commands: a..c open words 0..2, d..f short words 0..2
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_A = 8'h50;
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_B = 8'h51;
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_C = 8'h52;
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_D = 8'h53;
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_E = 8'h54;
  localparam logic [CMD_W-1:0] FAULT_READ_CMD_F = 8'h55;
  localparam logic [SUB_W-1:0] FAULT_SUB_NUM = 4'h6;

  localparam logic [ADDR_W-1:0] BCAST_ADDR = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RST = 48'h0;

  // Field positions inside the configuration words
  localparam int BLK_EXT_LSB = 41;
  localparam int BLK_EXT_W = 6;
  localparam int CC_W = 8;
  localparam int CC_R_LSB = 0;
  localparam int CC_G_LSB = 8;
  localparam int CC_B_LSB = 16;
  localparam int BC_LSB = 24;
  localparam int BC_W = 3;
  localparam int SCALE_W = 12;

  typedef enum logic {
    LMF_RX_IDLE,
    LMF_RX_SHIFT
  } lmf_rx_state_t;
endpackage

// *** tb.sv ***
// Self-checking bench for the frame command flow
`timescale 1ns/1ps
module tb;
  localparam logic [47:0] W1 = 48'h2800_0000_0000;
  localparam logic [47:0] W3 = 48'h0000_0354_A9FE;
  localparam logic [47:0] W0 = 48'h0123_4567_89AB;
  localparam logic [47:0] W2 = 48'h0A0B_0C0D_0E0F;
  logic core_clk_i, reset_i, sclk, serial_in, serial_out, bank, vsync, indexed;
  logic [lmf_pkg::FAULT_W-1:0] open_v, short_v;
  logic [3:0] disp_addr;
  logic [47:0] disp_data;
  logic [7:0] chip_addr;
  logic [5:0] blank;
  logic [2:0] bc;
  logic [11:0] red, green, blue;
  logic [63:0] rx_frame;
  logic [15:0] rx_count;
  int err_total, checks_done, cycles, vs_cnt;

  lmf_frame_cmd lmf_frame_cmd_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .serial_clk_i(sclk), .serial_in_i(serial_in), .led_open_detect_i(open_v),
    .led_short_detect_i(short_v), .display_addr_i(disp_addr), .serial_out_o(serial_out),
    .display_data_o(disp_data), .display_bank_o(bank), .vsync_pulse_o(vsync),
    .chip_address_o(chip_addr), .chip_indexed_o(indexed), .subperiod_blank_extension_o(blank),
    .global_brightness_code_o(bc), .red_current_scale_o(red), .green_current_scale_o(green),
    .blue_current_scale_o(blue));
  lmf_ctrl_model lmf_ctrl_model_i (.serial_clk_o(sclk), .serial_in_o(serial_in), .serial_out_i(serial_out),
    .rx_frame_o(rx_frame), .rx_count_o(rx_count));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (vsync === 1'b1) begin
      vs_cnt <= vs_cnt + 1;
    end
    if (cycles == 60000) begin
      err_total++;
      report_and_stop;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask

  // Sends one frame and waits until the device has forwarded it
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] addr, input logic [47:0] pay);
    logic [15:0] n;
    n = rx_count;
    lmf_ctrl_model_i.send(cmd, addr, pay);
    for (int k = 0; k < 4000 && rx_count == n; k++) @(posedge core_clk_i);
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask

  task automatic show_row(input logic [3:0] row, input logic [47:0] exp);
    @(posedge core_clk_i);
    disp_addr <= row;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk("display_row", disp_data, exp);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    disp_addr = 4'h0;
    err_total = 0;
    checks_done = 0;
    cycles = 0;
    vs_cnt = 0;
    open_v = {48'hA3A3_0000_0003, 48'hA2A2_0000_0002, 48'hA1A1_0000_0001};
    short_v = {48'hB3B3_0000_0003, 48'hB2B2_0000_0002, 48'hB1B1_0000_0001};
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    chk("chip_address", chip_addr, 8'h00);
    chk("chip_indexed", indexed, 1'b0);
    xfer(8'h10, 8'h05, 48'h0);
    chk("chip_address", chip_addr, 8'h05);
    chk("chip_indexed", indexed, 1'b1);
    chk("index_forward", rx_frame, {8'h10, 8'h06, 48'h0});
    xfer(8'h21, lmf_pkg::BCAST_ADDR, W1);
    xfer(8'h23, lmf_pkg::BCAST_ADDR, W3);
    xfer(8'h20, lmf_pkg::BCAST_ADDR, W0);
    xfer(8'h22, lmf_pkg::BCAST_ADDR, W2);
    xfer(8'h42, 8'h05, 48'h0);
    chk("read_immediate", rx_frame, {8'h42, 8'h05, W2});
    xfer(8'h40, 8'h05, 48'h0);
    chk("read_staged0", rx_frame, {8'h40, 8'h05, 48'h0});
    chk("blank_staged", blank, 6'h00);
    xfer(8'h41, 8'h05, 48'h0);
    chk("read_staged", rx_frame, {8'h41, 8'h05, 48'h0});
    chk("brightness", bc, 3'h3);
    chk("red_scale", red, 12'h3F8);
    chk("green_scale", green, 12'h2A4);
    chk("blue_scale", blue, 12'h150);
    xfer(8'h30, lmf_pkg::BCAST_ADDR, 48'h0);
    chk("blank_active", blank, 6'h14);
    chk("bank", bank, 1'b1);
    chk("sync_pulses", vs_cnt, 1);
    xfer(8'h41, 8'h05, 48'h0);
    chk("read_active", rx_frame, {8'h41, 8'h05, W1});
    xfer(8'h40, 8'h05, 48'h0);
    chk("read_active0", rx_frame, {8'h40, 8'h05, W0});
    // Column fifteen first, as wired, then a write for another device between
    xfer(8'h20, 8'h05, 48'h0F0F_0000_1515);
    xfer(8'h20, 8'h07, 48'hDEAD_0000_0707);
    xfer(8'h20, 8'h05, 48'h0E0E_0000_1414);
    for (int k = 0; k < 6; k++) begin
      xfer(lmf_pkg::FAULT_READ_CMD_A + k[7:0], 8'h05, 48'h0);
      chk("fault_flags", rx_frame[47:0], (k < 3) ? open_v[48*k +: 48] : short_v[48*(k-3) +: 48]);
    end
    xfer(8'h30, lmf_pkg::BCAST_ADDR, 48'h0);
    chk("bank", bank, 1'b0);
    chk("sync_pulses", vs_cnt, 2);
    show_row(4'h0, 48'h0F0F_0000_1515);
    show_row(4'h1, 48'h0E0E_0000_1414);
    report_and_stop;
  end
endmodule
